// ===== test/mode_strap_host.sv
`timescale 1ns/1ps
module mode_strap_host (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_level,
   output logic      o_strap
);
   // strap held through reset
   // level only moves while reset is low, so capture never sees a change
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_strap <= i_level;
      end
   end
endmodule // mode_strap_host

// ===== test/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
   import chip_cfg_pkg::*;
   logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic        secured, level, strap, hit, mon, dbg_act, dbg_en, frz;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] laddr;
   logic [17:0] gaddr;
   int          error_cnt, n_compared, cyc;
   localparam logic [15:0] ID = {ID_MAJ_FAM, ID_MIN_FAM, ID_MAJ_REV,
                                 ID_MIN_REV};
   mode_strap_host i_mode_strap_host (.i_clk(mclk), .i_rst_n(rst_n),
      .i_level(level), .o_strap(strap));
   chip_mode_and_part_id i_chip_mode_and_part_id (.I_MCLK(mclk),
      .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .I_MODE_STRAP(strap), .I_SECURED(secured), .I_LOCAL_ADDR(laddr),
      .O_GLOBAL_ADDR(gaddr), .O_WINDOW_HIT(hit), .O_BOOT_MONITOR(mon),
      .O_DEBUG_UNIT_ACTIVE(dbg_act), .O_DEBUG_ENABLE(dbg_en),
      .O_FREEZE(frz));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rst(input logic lv, input logic sec);
      level <= lv; secured <= sec; rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      `CHK({pready, pslverr, mon, dbg_act, dbg_en, frz}, 6'h20)
      rst_n <= 1'b1;
      repeat (6) @(posedge mclk);
   endtask
   task automatic t_ids();
      apb(1'b0, ADDR_PART_ID_HIGH, 32'h0);
      `CHK(rd[7:0], ID[15:8])
      apb(1'b0, ADDR_PART_ID_LOW, 32'h0);
      `CHK(rd[7:0], ID[7:0])
      apb(1'b1, ADDR_PART_ID_LOW, 32'hFF);
      apb(1'b0, ADDR_PART_ID_LOW, 32'h0);
      `CHK({err, rd[7:0]}, {1'b0, ID[7:0]})
      apb(1'b0, ADDR_NVM_VERSION, 32'h0);
      `CHK(rd[15:0], NVM_VERSION)
      apb(1'b0, 12'h0F0, 32'h0);
      `CHK({err, rd}, {1'b1, RD_ZERO})
   endtask
   task automatic t_special();
      rst(1'b0, 1'b1);
      apb(1'b0, ADDR_MODE, 32'h0);
      `CHK(rd[1:0], 2'h2)
      `CHK({mon, dbg_act, dbg_en}, 3'h7)
      apb(1'b1, ADDR_DEBUG_CTRL, 32'h1);
      repeat (2) @(posedge mclk);
      `CHK(frz, 1'b1)
      apb(1'b1, ADDR_MODE, 32'h1);
      apb(1'b1, ADDR_MODE, 32'h0);
      apb(1'b0, ADDR_MODE, 32'h0);
      `CHK(rd[1:0], 2'h3)
      `CHK({mon, dbg_act, dbg_en, frz}, 4'h0)
      apb(1'b0, ADDR_PART_ID_HIGH, 32'h0);
      `CHK(rd[7:0], ID[15:8])
   endtask
   task automatic t_normal();
      rst(1'b1, 1'b0);
      apb(1'b0, ADDR_MODE, 32'h0);
      `CHK(rd[1:0], 2'h3)
      `CHK({mon, dbg_act, dbg_en}, 3'h1)
      secured <= 1'b1;
      repeat (3) @(posedge mclk);
      `CHK(dbg_en, 1'b0)
   endtask
   task automatic t_window();
      logic [15:0] la[4];
      la = '{16'h7FFF, 16'h8000, 16'hBFFF, 16'hC000};
      apb(1'b0, ADDR_PAGE, 32'h0);
      `CHK(rd[7:0], PAGE_RST)
      apb(1'b1, ADDR_PAGE, 32'h5);
      for (int i = 0; i < 4; i++) begin
         laddr <= la[i];
         repeat (2) @(posedge mclk);
         `CHK(hit, (i == 1 || i == 2))
         `CHK(gaddr, {4'h5, la[i][13:0]})
      end
   endtask
   task automatic stop_test();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // bench runs well under 1000 cycles, so this only cuts a hang
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         stop_test();
      end
   end
   initial begin
      rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h0; pwdata = 32'h0; secured = 1'b0; level = 1'b1;
      laddr = 16'h0; error_cnt = 0; n_compared = 0; cyc = 0;
      rst(1'b1, 1'b0);
      t_ids();
      t_window();
      t_special();
      t_normal();
      stop_test();
   end
endmodule // tb_top

// ===== verilog/chip_cfg_pkg.sv
package chip_cfg_pkg;

   // register byte addresses (indices 0x1A/0x1B are not word aligned)
   localparam logic [7:0]  IDX_PART_ID_HIGH = 8'h1A;
   localparam logic [7:0]  IDX_PART_ID_LOW  = 8'h1B;
   localparam logic [11:0] ADDR_PART_ID_HIGH = {2'h0, IDX_PART_ID_HIGH, 2'h0};
   localparam logic [11:0] ADDR_PART_ID_LOW  = {2'h0, IDX_PART_ID_LOW, 2'h0};
   // own choices for the remaining controls
   localparam logic [11:0] ADDR_MODE        = 12'h080;
   localparam logic [11:0] ADDR_PAGE        = 12'h084;
   localparam logic [11:0] ADDR_NVM_VERSION = 12'h088;
   localparam logic [11:0] ADDR_DEBUG_CTRL  = 12'h08C;

   // identifier fields
   localparam int ID_MAJ_FAM_LSB = 12;
   localparam int ID_MIN_FAM_LSB = 6;
   localparam int ID_MAJ_REV_LSB = 4;
   localparam int ID_MIN_REV_LSB = 0;

   // value is arbitrary
   localparam logic [3:0] ID_MAJ_FAM = 4'h5;
   localparam logic [5:0] ID_MIN_FAM = 6'h0A;
   localparam logic [1:0] ID_MAJ_REV = 2'h1;
   localparam logic [3:0] ID_MIN_REV = 4'h2;
   // value is arbitrary
   localparam logic [15:0] NVM_VERSION = 16'h1234;

   // strap capture waits out both sync stages
   localparam logic [1:0]  SETTLE_LAST = 2'h2;

   // paged window 0x8000-0xBFFF in a 256k space
   localparam logic [15:0] WIN_LO    = 16'h8000;
   localparam logic [15:0] WIN_HI    = 16'hBFFF;
   localparam int          WIN_BITS  = 14;
   localparam logic [7:0]  PAGE_RST  = 8'h0F;
   localparam logic [3:0]  PAGE_MASK = 4'hF;

   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   typedef enum logic {MODE_SPECIAL, MODE_NORMAL} chip_mode_e;

   typedef struct packed {
      logic [11:0] addr;
      logic        write;
      logic [31:0] wdata;
      logic        sel;
      logic        enable;
   } apb_req_s;

   typedef struct packed {
      logic [17:0] addr;
      logic        hit;
   } win_s;

endpackage

// ===== verilog/chip_mode_and_part_id.sv
// Overview of operation
// - id high/low bytes, read-only registers
// - id fields: family, minor family, revisions
// - fixed id, differs per silicon revision
// - separate 16-bit nvm controller version word
// - strap captured on the third clock after reset release
// - strap 1 normal, 0 special mode
// - mode readable, limited switching at run
// - normal mode boots from on-chip vector
// - special mode: debug unit on, monitor
// - debug enable from mode and security
// - paged program-flash window 0x8000-0xBFFF
// - freeze option while debug unit active
`timescale 1ns/1ps
module chip_mode_and_part_id
   import chip_cfg_pkg::*;
(
   input  wire logic        I_MCLK,
   input  wire logic        I_RST_N,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [11:0] I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   input  wire logic        I_MODE_STRAP,
   input  wire logic        I_SECURED,
   input  wire logic [15:0] I_LOCAL_ADDR,
   output logic      [17:0] O_GLOBAL_ADDR,
   output logic             O_WINDOW_HIT,
   output logic             O_BOOT_MONITOR,
   output logic             O_DEBUG_UNIT_ACTIVE,
   output logic             O_DEBUG_ENABLE,
   output logic             O_FREEZE
);
   apb_req_s    req;
   win_s        win;
   logic        strap_meta;
   logic        strap_sync;
   logic        captured;
   chip_mode_e  mode;
   logic [7:0]  page;
   logic        freeze_en;
   logic        wr_en;
   logic        rd_en;
   logic        mapped;
   logic [31:0] next_rdata;
   logic [15:0] part_id;

   assign req = '{addr: I_PADDR, write: I_PWRITE, wdata: I_PWDATA,
                  sel: I_PSEL, enable: I_PENABLE};

   assign part_id = {ID_MAJ_FAM, ID_MIN_FAM, ID_MAJ_REV, ID_MIN_REV};

   // strap comes from a pin, so two flops first
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         strap_meta <= 1'b0;
         strap_sync <= 1'b0;
      end else begin
         strap_meta <= I_MODE_STRAP;
         strap_sync <= strap_meta;
      end
   end

   // software may only leave special mode
   // async reset cannot load a pin, so capture waits for the sync stages
   logic [1:0] settle;
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         settle   <= 2'h0;
         captured <= 1'b0;
         mode     <= MODE_SPECIAL;
      end else begin
         if (!captured) begin
            if (settle == SETTLE_LAST) begin
               captured <= 1'b1;
               mode     <= strap_sync ? MODE_NORMAL : MODE_SPECIAL;
            end else begin
               settle <= settle + 2'h1;
            end
         end else if (wr_en && req.addr == ADDR_MODE &&
                      mode == MODE_SPECIAL && req.wdata[0]) begin
            mode <= MODE_NORMAL;
         end
      end
   end

   assign wr_en  = req.sel && req.enable && req.write;
   assign rd_en  = req.sel && req.enable && !req.write;

   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         page <= PAGE_RST;
      end else if (wr_en && req.addr == ADDR_PAGE) begin
         page <= {4'h0, req.wdata[3:0] & PAGE_MASK};
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         freeze_en <= 1'b0;
      end else if (wr_en && req.addr == ADDR_DEBUG_CTRL) begin
         freeze_en <= req.wdata[0];
      end
   end

   always_comb begin
      next_rdata = RD_ZERO;
      mapped     = 1'b1;
      if (req.addr == ADDR_PART_ID_HIGH) begin
         next_rdata = {24'h0, part_id[15:8]};
      end else if (req.addr == ADDR_PART_ID_LOW) begin
         next_rdata = {24'h0, part_id[7:0]};
      end else if (req.addr == ADDR_MODE) begin
         next_rdata = {30'h0, captured, mode == MODE_NORMAL};
      end else if (req.addr == ADDR_PAGE) begin
         next_rdata = {24'h0, page};
      end else if (req.addr == ADDR_NVM_VERSION) begin
         next_rdata = {16'h0, NVM_VERSION};
      end else if (req.addr == ADDR_DEBUG_CTRL) begin
         next_rdata = {31'h0, freeze_en};
      end else begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PRDATA <= RD_ZERO;
      end else if (req.sel && !req.enable && !req.write) begin
         O_PRDATA <= next_rdata;
      end
   end

   // zero wait states; unmapped access answers with an error
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = req.sel && req.enable && !mapped;

   page_window i_page_window (
      .i_clk        (I_MCLK),
      .i_rst_n      (I_RST_N),
      .i_local_addr (I_LOCAL_ADDR),
      .i_page       (page),
      .o_win        (win)
   );
   assign O_GLOBAL_ADDR = win.addr;
   assign O_WINDOW_HIT  = win.hit;

   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_BOOT_MONITOR <= 1'b0;
      end else begin
         O_BOOT_MONITOR <= captured && mode == MODE_SPECIAL;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_DEBUG_UNIT_ACTIVE <= 1'b0;
      end else begin
         O_DEBUG_UNIT_ACTIVE <= captured && mode == MODE_SPECIAL;
      end
   end

   // debug gated by security in normal mode only; special mode enables it regardless
   // held off until strap known: no early debug window
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_DEBUG_ENABLE <= 1'b0;
      end else begin
         O_DEBUG_ENABLE <= captured && (mode == MODE_SPECIAL || !I_SECURED);
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_FREEZE <= 1'b0;
      end else begin
         O_FREEZE <= freeze_en && captured && mode == MODE_SPECIAL;
      end
   end

   a_id_high_fixed: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (req.sel && !req.enable && !req.write &&
       req.addr == ADDR_PART_ID_HIGH) |=>
      O_PRDATA == {24'h0, part_id[15:8]})
      else $error("id high byte wrong");

   a_id_fields: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      part_id[ID_MAJ_FAM_LSB +: 4] == ID_MAJ_FAM &&
      part_id[ID_MIN_FAM_LSB +: 6] == ID_MIN_FAM &&
      part_id[ID_MAJ_REV_LSB +: 2] == ID_MAJ_REV &&
      part_id[ID_MIN_REV_LSB +: 4] == ID_MIN_REV)
      else $error("id field layout wrong");

   a_id_low_fixed: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (req.sel && !req.enable && !req.write &&
       req.addr == ADDR_PART_ID_LOW) |=>
      O_PRDATA == {24'h0, part_id[7:0]})
      else $error("id low byte wrong");

   a_id_write_quiet: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (wr_en && (req.addr == ADDR_PART_ID_HIGH ||
                 req.addr == ADDR_PART_ID_LOW)) |-> !O_PSLVERR)
      else $error("id write flagged");

   a_read_stable: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      rd_en |=> $stable(O_PRDATA))
      else $error("read data moved");

   a_nvm_version: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (req.sel && !req.enable && !req.write &&
       req.addr == ADDR_NVM_VERSION) |=>
      O_PRDATA == {16'h0, NVM_VERSION})
      else $error("version word wrong");

   a_mode_capture: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (!captured && settle == SETTLE_LAST) |=>
      (captured && (mode == MODE_NORMAL) == $past(strap_sync)))
      else $error("strap not captured");

   a_capture_held: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      captured |=> captured)
      else $error("capture lost");

   a_quiet_before: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      !captured |-> !O_BOOT_MONITOR && !O_DEBUG_ENABLE)
      else $error("mode output before capture");

   a_mode_read: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (req.sel && !req.enable && !req.write && req.addr == ADDR_MODE) |=>
      O_PRDATA[0] == ($past(mode) == MODE_NORMAL))
      else $error("mode read wrong");

   a_mode_sticky: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      ($past(captured) && $past(mode) == MODE_NORMAL) |->
      mode == MODE_NORMAL)
      else $error("mode left normal");

   a_special_exit: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (captured && mode == MODE_SPECIAL && wr_en &&
       req.addr == ADDR_MODE && req.wdata[0]) |=> mode == MODE_NORMAL)
      else $error("special exit refused");

   a_normal_boot: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (captured && mode == MODE_NORMAL) |=> !O_BOOT_MONITOR)
      else $error("monitor in normal mode");

   a_monitor_special: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (captured && mode == MODE_SPECIAL) |=> O_BOOT_MONITOR)
      else $error("monitor not started");

   a_debug_unit_on: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (captured && mode == MODE_SPECIAL) |=> O_DEBUG_UNIT_ACTIVE)
      else $error("debug unit idle in special");

   a_debug_secure: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (captured && mode == MODE_NORMAL && I_SECURED) |=> !O_DEBUG_ENABLE)
      else $error("debug open while secured");

   a_debug_open: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (captured && (mode == MODE_SPECIAL || !I_SECURED)) |=> O_DEBUG_ENABLE)
      else $error("debug closed when allowed");

   a_page_write: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (wr_en && req.addr == ADDR_PAGE) |=>
      page == {4'h0, $past(req.wdata[3:0])})
      else $error("page select not written");

   a_window_map: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (I_LOCAL_ADDR == WIN_LO) |=> (O_WINDOW_HIT &&
      O_GLOBAL_ADDR[17:14] == $past(page[3:0])))
      else $error("window map wrong");

   a_window_miss: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (I_LOCAL_ADDR < WIN_LO || I_LOCAL_ADDR > WIN_HI) |=> !O_WINDOW_HIT)
      else $error("hit outside window");

   a_window_offset: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      $past(I_RST_N) |->
      O_GLOBAL_ADDR[WIN_BITS-1:0] == $past(I_LOCAL_ADDR[WIN_BITS-1:0]))
      else $error("window offset wrong");

   a_freeze_gate: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      O_FREEZE |-> $past(freeze_en))
      else $error("freeze without option");

   a_freeze_special: assert property (
      @(posedge I_MCLK) disable iff (!I_RST_N)
      (freeze_en && captured && mode == MODE_SPECIAL) |=> O_FREEZE)
      else $error("freeze option ignored");
endmodule // chip_mode_and_part_id

// ===== verilog/page_window.sv
`timescale 1ns/1ps
module page_window
   import chip_cfg_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic [15:0] i_local_addr,
   input  wire logic [7:0]  i_page,
   output win_s             o_win
);
   win_s next_win;

   always_comb begin
      next_win.hit  = (i_local_addr >= WIN_LO) && (i_local_addr <= WIN_HI);
      next_win.addr = {i_page[3:0], i_local_addr[WIN_BITS-1:0]};
   end

   // registered so the global address is a flop output
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_win <= '0;
      end else begin
         o_win <= next_win;
      end
   end
endmodule // page_window
